// ### src/mps_pkg.sv
package mps_pkg;

    // Partial-store selector codes
    localparam logic [7:0] BYTE_LANE_PRIMARY_SEL = 8'hc0;
    localparam logic [7:0] BYTE_LANE_SECONDARY_SEL = 8'hc1;
    localparam logic [7:0] HALF_LANE_PRIMARY_SEL = 8'hc2;
    localparam logic [7:0] HALF_LANE_SECONDARY_SEL = 8'hc3;
    localparam logic [7:0] WORD_LANE_PRIMARY_SEL = 8'hc4;
    localparam logic [7:0] WORD_LANE_SECONDARY_SEL = 8'hc5;
    localparam logic [7:0] BYTE_LANE_PRIMARY_LE_SEL = 8'hc8;
    localparam logic [7:0] BYTE_LANE_SECONDARY_LE_SEL = 8'hc9;
    localparam logic [7:0] HALF_LANE_PRIMARY_LE_SEL = 8'hca;
    localparam logic [7:0] HALF_LANE_SECONDARY_LE_SEL = 8'hcb;
    localparam logic [7:0] WORD_LANE_PRIMARY_LE_SEL = 8'hcc;
    localparam logic [7:0] WORD_LANE_SECONDARY_LE_SEL = 8'hcd;

    // Field positions inside the selector, and the address alignment width
    localparam int SEL_SPACE_BIT = 0;
    localparam int SEL_LE_BIT = 3;
    localparam int ALIGN_BITS = 3;

    typedef enum logic [1:0] {
        MPS_LANE_BYTE = 2'b00,
        MPS_LANE_HALF = 2'b01,
        MPS_LANE_WORD = 2'b10,
        MPS_LANE_NONE = 2'b11
    } mps_lane_e;

    // Request from decode
    typedef struct packed {
        logic is_alt_store;
        logic imm_sel;
        logic [7:0] space_sel;
        logic [63:0] addr;
        logic [63:0] lane_mask;
        logic [63:0] fp_data;
    } mps_req_s;

    // Store going to the load-store path
    typedef struct packed {
        logic secondary;
        logic [63:0] addr;
        logic [7:0] byte_en;
        logic [63:0] data;
    } mps_store_s;

    // Watchpoint configuration
    typedef struct packed {
        logic [63:0] va_addr;
        logic [63:0] pa_addr;
        logic [7:0] va_mask;
        logic [7:0] pa_mask;
    } mps_watch_s;

    // Trap vector
    typedef struct packed {
        logic float_unit_off_trap;
        logic illegal_opcode;
        logic misaligned;
        logic virtual_watch_trap;
        logic physical_watch_trap;
        logic data_access_exc;
        logic data_access_err;
        logic quick_translation_miss_trap;
        logic quick_protection_trap;
    } mps_trap_s;

    localparam mps_trap_s TRAP_NONE = '0;
    localparam mps_store_s STORE_NONE = '0;

endpackage

// ### src/mps_lane_map.sv
`timescale 1ns/10ps
// Turns lane mask and lane width into a byte enable, and orders the data
module mps_lane_map
(
    // Selection
    input wire mps_pkg::mps_lane_e lane_in,
    input wire logic little_in,
    // Operands
    input wire logic [63:0] mask_in,
    input wire logic [63:0] data_in,
    // Result, byte 0 at the lowest memory address
    output logic [7:0] byte_en_out,
    output logic [63:0] data_out
);

    logic [7:0] en_reg;
    logic [63:0] be_data;

    // Mask bit 0 names the least significant lane; only as many low bits count
    // as there are lanes, so stray upper mask bits are ignored
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_byte
            assign en_reg[g] = (lane_in == mps_pkg::MPS_LANE_BYTE) ? mask_in[g] :
                (lane_in == mps_pkg::MPS_LANE_HALF) ? mask_in[g / 2] :
                (lane_in == mps_pkg::MPS_LANE_WORD) ? mask_in[g / 4] : 1'b0;
            // Big-endian: most significant register byte at lowest address
            assign be_data[8 * (7 - g) +: 8] = data_in[8 * g +: 8];
        end
    endgenerate

    // Little-endian swaps bytes within each lane only
    function automatic logic [63:0] le_swap(input mps_pkg::mps_lane_e l, input logic [63:0] d);
        logic [63:0] r;
        r = d;
        for (int i = 0; i < 8; i++)
        begin
            if (l == mps_pkg::MPS_LANE_HALF)
            begin
                r[8 * i +: 8] = d[8 * (i ^ 1) +: 8];
            end
            else if (l == mps_pkg::MPS_LANE_WORD)
            begin
                r[8 * i +: 8] = d[8 * (i ^ 3) +: 8];
            end
        end
        return r;
    endfunction

    // Memory byte k takes register byte 7-k (big) or lane-swapped (little)
    logic [7:0] be_en;
    generate
        for (g = 0; g < 8; g++)
        begin : g_pos
            assign be_en[g] = en_reg[7 - g];
        end
    endgenerate

    logic [63:0] le_data;
    assign le_data = le_swap(lane_in, be_data);
    assign byte_en_out = be_en;
    assign data_out = little_in ? le_data : be_data;

endmodule

// ### src/mps_store_unit.sv
`timescale 1ns/10ps
// Functional notes
// - Partial store happens only for alternate-space double store with a partial-store selector.
// - Selector picks eight byte, four half or two word lanes.
// - Even selector codes use primary space, odd codes secondary space.
// - Selectors C8 to CD store little-endian; others big-endian.
// - Data from the fp register, address from first source, mask from second.
// - Highest used mask bit governs the most significant lane.
// - Mask bit 0 is the least significant lane.
// - Watch trap needs address match, some byte stored, and a watched byte.
// - Watch logic may treat every partial store as writing all bytes.
// - Watch logic may treat any nonzero watch mask as all bytes watched.
// - Immediate-select bit set raises illegal opcode trap.
// - Float-off, misaligned, access exception, error, miss and protection traps are reported.
module mps_store_unit
#(
    parameter bit WATCH_FULL_STORE = 1'b0,
    parameter bit WATCH_ANY_MASK = 1'b0
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Decode side
    input wire logic req_valid_in,
    input wire mps_pkg::mps_req_s req_in,
    input wire logic fpu_enabled_in,
    // Watchpoint configuration from the cache unit control register
    input wire mps_pkg::mps_watch_s watch_in,
    // Translation results from the MMU for this request
    input wire logic mmu_access_exc_in,
    input wire logic mmu_access_err_in,
    input wire logic mmu_miss_in,
    input wire logic mmu_prot_in,
    // Load-store path
    output logic store_valid_out,
    output mps_pkg::mps_store_s store_out,
    // Traps and completion
    output logic done_out,
    output logic not_partial_out,
    output mps_pkg::mps_trap_s trap_out
);

    logic store_valid_r;
    mps_pkg::mps_store_s store_r;
    logic done_r;
    logic not_partial_r;
    mps_pkg::mps_trap_s trap_r;

    wire [7:0] sel = req_in.space_sel;
    wire is_byte = (sel == mps_pkg::BYTE_LANE_PRIMARY_SEL)
        || (sel == mps_pkg::BYTE_LANE_SECONDARY_SEL)
        || (sel == mps_pkg::BYTE_LANE_PRIMARY_LE_SEL)
        || (sel == mps_pkg::BYTE_LANE_SECONDARY_LE_SEL);
    wire is_half = (sel == mps_pkg::HALF_LANE_PRIMARY_SEL)
        || (sel == mps_pkg::HALF_LANE_SECONDARY_SEL)
        || (sel == mps_pkg::HALF_LANE_PRIMARY_LE_SEL)
        || (sel == mps_pkg::HALF_LANE_SECONDARY_LE_SEL);
    wire is_word = (sel == mps_pkg::WORD_LANE_PRIMARY_SEL)
        || (sel == mps_pkg::WORD_LANE_SECONDARY_SEL)
        || (sel == mps_pkg::WORD_LANE_PRIMARY_LE_SEL)
        || (sel == mps_pkg::WORD_LANE_SECONDARY_LE_SEL);
    wire is_partial = is_byte || is_half || is_word;
    wire take = req_valid_in && req_in.is_alt_store && is_partial;
    // Non-partial alternate stores are left to the ordinary store path
    wire other = req_valid_in && !(req_in.is_alt_store && is_partial);

    mps_pkg::mps_lane_e lane;
    assign lane = is_byte ? mps_pkg::MPS_LANE_BYTE :
        is_half ? mps_pkg::MPS_LANE_HALF :
        is_word ? mps_pkg::MPS_LANE_WORD : mps_pkg::MPS_LANE_NONE;
    wire secondary = sel[mps_pkg::SEL_SPACE_BIT];
    wire little = sel[mps_pkg::SEL_LE_BIT];

    logic [7:0] byte_en;
    logic [63:0] mem_data;
    mps_lane_map u_map
    (
        .lane_in(lane),
        .little_in(little),
        .mask_in(req_in.lane_mask),
        .data_in(req_in.fp_data),
        .byte_en_out(byte_en),
        .data_out(mem_data)
    );

    // Watchpoint check on the 8-byte aligned doubleword
    wire [7:0] watch_bytes = WATCH_FULL_STORE ? 8'hff : byte_en;
    wire [7:0] va_watch = (WATCH_ANY_MASK && (|watch_in.va_mask)) ? 8'hff : watch_in.va_mask;
    wire [7:0] pa_watch = (WATCH_ANY_MASK && (|watch_in.pa_mask)) ? 8'hff : watch_in.pa_mask;
    wire va_hit = (req_in.addr[63:3] == watch_in.va_addr[63:3])
        && (|byte_en) && (|(watch_bytes & va_watch));
    // Physical address is supplied on the same address field after translation
    wire pa_hit = (req_in.addr[63:3] == watch_in.pa_addr[63:3])
        && (|byte_en) && (|(watch_bytes & pa_watch));

    mps_pkg::mps_trap_s trap_nxt;
    always_comb
    begin
        trap_nxt = mps_pkg::TRAP_NONE;
        trap_nxt.float_unit_off_trap = !fpu_enabled_in;
        trap_nxt.illegal_opcode = req_in.imm_sel;
        trap_nxt.misaligned = |req_in.addr[mps_pkg::ALIGN_BITS - 1:0];
        trap_nxt.data_access_exc = mmu_access_exc_in;
        trap_nxt.data_access_err = mmu_access_err_in;
        trap_nxt.quick_translation_miss_trap = mmu_miss_in;
        trap_nxt.quick_protection_trap = mmu_prot_in;
        trap_nxt.virtual_watch_trap = va_hit;
        trap_nxt.physical_watch_trap = pa_hit;
    end

    wire any_trap = |trap_nxt;
    // Any trap suppresses the memory write entirely
    wire do_store = take && !any_trap;

    mps_pkg::mps_store_s store_nxt;
    always_comb
    begin
        store_nxt = mps_pkg::STORE_NONE;
        store_nxt.secondary = secondary;
        store_nxt.addr = req_in.addr;
        store_nxt.byte_en = byte_en;
        store_nxt.data = mem_data;
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            store_valid_r <= 1'b0;
            store_r <= mps_pkg::STORE_NONE;
            done_r <= 1'b0;
            not_partial_r <= 1'b0;
            trap_r <= mps_pkg::TRAP_NONE;
        end
        else
        begin
            store_valid_r <= do_store;
            store_r <= do_store ? store_nxt : mps_pkg::STORE_NONE;
            done_r <= take;
            not_partial_r <= other;
            trap_r <= take ? trap_nxt : mps_pkg::TRAP_NONE;
        end
    end

    assign store_valid_out = store_valid_r;
    assign store_out = store_r;
    assign done_out = done_r;
    assign not_partial_out = not_partial_r;
    assign trap_out = trap_r;

endmodule

// ### verification/mps_mem_model.sv
`timescale 1ns/10ps
// Byte-wide memory behind the load-store path; only enabled bytes change
module mps_mem_model
(
    // Clock
    input wire logic clock_in,
    // Store path
    input wire logic store_valid_in,
    input wire mps_pkg::mps_store_s store_in
);
    logic [7:0] mem_r [64];
    always_ff @(posedge clock_in)
    begin
        for (int k = 0; k < 8; k++)
        begin
            if (store_valid_in && store_in.byte_en[k])
            begin
                mem_r[{store_in.addr[5:3], 3'(k)}] <= store_in.data[8*k +: 8];
            end
        end
    end
endmodule

// ### verification/mps_store_unit_asserts.sv
`timescale 1ns/10ps
module mps_store_unit_asserts
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // Decode side
    input wire logic req_valid_in,
    input wire mps_pkg::mps_req_s req_in,
    input wire logic fpu_enabled_in,
    input wire mps_pkg::mps_watch_s watch_in,
    input wire logic mmu_access_exc_in,
    input wire logic mmu_access_err_in,
    input wire logic mmu_miss_in,
    input wire logic mmu_prot_in,
    // Results
    input wire logic store_valid_out,
    input wire mps_pkg::mps_store_s store_out,
    input wire logic done_out,
    input wire logic not_partial_out,
    input wire mps_pkg::mps_trap_s trap_out
);
    wire sel_ok = req_in.space_sel[7:4] == 4'hc && req_in.space_sel[2:1] != 2'b11;
    wire take = req_valid_in && req_in.is_alt_store && sel_ok;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    property p_take; take |=> done_out && !not_partial_out; endproperty
    property p_skip; req_valid_in && !take |=> not_partial_out && !done_out; endproperty
    property p_imm; take && req_in.imm_sel |=> trap_out.illegal_opcode; endproperty
    property p_align; take && req_in.addr[2:0] != 3'h0 |=> trap_out.misaligned; endproperty
    property p_fpu; take && !fpu_enabled_in |=> trap_out.float_unit_off_trap; endproperty
    property p_clean; store_valid_out |-> done_out && trap_out == mps_pkg::TRAP_NONE; endproperty
    property p_space; store_valid_out |-> store_out.secondary == $past(req_in.space_sel[0]); endproperty
    property p_addr; store_valid_out |-> store_out.addr == $past(req_in.addr); endproperty
    property p_none; take && req_in.lane_mask[7:0] == 8'h0 |=> store_out.byte_en == 8'h0; endproperty
    a_take: assert property (p_take) else $error("partial store not completed");
    a_skip: assert property (p_skip) else $error("other store not passed by");
    a_imm: assert property (p_imm) else $error("immediate form not refused");
    a_align: assert property (p_align) else $error("misaligned address not trapped");
    a_fpu: assert property (p_fpu) else $error("disabled float unit not trapped");
    a_clean: assert property (p_clean) else $error("write issued beside a trap");
    a_space: assert property (p_space) else $error("wrong address space");
    a_addr: assert property (p_addr) else $error("wrong store address");
    a_none: assert property (p_none) else $error("empty mask wrote bytes");
    c_store: cover property (store_valid_out);
    c_watch: cover property (trap_out.virtual_watch_trap);
    c_skip: cover property (not_partial_out);
endmodule
bind mps_store_unit mps_store_unit_asserts mps_store_unit_asserts_inst (
    .clock_in(clock_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .fpu_enabled_in(fpu_enabled_in), .watch_in(watch_in), .mmu_prot_in(mmu_prot_in),
    .mmu_access_exc_in(mmu_access_exc_in), .mmu_access_err_in(mmu_access_err_in),
    .mmu_miss_in(mmu_miss_in), .store_valid_out(store_valid_out), .store_out(store_out),
    .done_out(done_out), .not_partial_out(not_partial_out), .trap_out(trap_out));

// ### verification/mps_store_unit_bench.sv
`timescale 1ns/10ps
module mps_store_unit_bench;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("FAIL %s expected %h seen %h", n, e, g); end end
    typedef struct packed {
        logic done;
        logic np;
        mps_pkg::mps_trap_s trap;
        mps_pkg::mps_store_s st;
    } mps_exp_s;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    mps_pkg::mps_req_s req_in = '0;
    logic fpu_enabled_in = 1'b1;
    mps_pkg::mps_watch_s watch_in = '0;
    logic [3:0] mmu = 4'h0;
    logic store_valid_out, done_out, not_partial_out;
    mps_pkg::mps_store_s store_out;
    mps_pkg::mps_trap_s trap_out;
    int fails = 0;
    int samples_checked = 0;
    mps_exp_s e0 = '0;
    // Expected contents of the memory model; bytes never written stay unknown on both sides
    logic [7:0] shadow [64];
    logic [7:0] sels [12] = '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5,
        8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd};
    always #4 clock_in = ~clock_in;
    mps_store_unit mps_store_unit_inst (.clock_in(clock_in), .rst_in(rst_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .fpu_enabled_in(fpu_enabled_in),
        .watch_in(watch_in), .mmu_access_exc_in(mmu[3]), .mmu_access_err_in(mmu[2]),
        .mmu_miss_in(mmu[1]), .mmu_prot_in(mmu[0]), .store_valid_out(store_valid_out),
        .store_out(store_out), .done_out(done_out), .not_partial_out(not_partial_out),
        .trap_out(trap_out));
    mps_mem_model mps_mem_model_inst (.clock_in(clock_in), .store_valid_in(store_valid_out),
        .store_in(store_out));
    function automatic mps_exp_s predict(mps_pkg::mps_req_s r, logic f, logic [3:0] m);
        mps_exp_s e;
        int wd, n, i, j;
        e = '0;
        if (!(r.is_alt_store && r.space_sel[7:4] == 4'hc && r.space_sel[2:1] != 2'b11))
        begin
            e.np = 1'b1;
            return e;
        end
        wd = 1 << r.space_sel[2:1];
        n = 8 / wd;
        for (int k = 0; k < 8; k++)
        begin
            i = n - 1 - k / wd;
            j = r.space_sel[3] ? k % wd : wd - 1 - k % wd;
            e.st.data[8*k +: 8] = r.fp_data[8*(i*wd+j) +: 8];
            e.st.byte_en[k] = r.lane_mask[i];
        end
        e.done = 1'b1;
        e.trap.float_unit_off_trap = !f;
        e.trap.illegal_opcode = r.imm_sel;
        e.trap.misaligned = r.addr[2:0] != 3'h0;
        e.trap.virtual_watch_trap = r.addr[63:3] == watch_in.va_addr[63:3] &&
            |(e.st.byte_en & watch_in.va_mask);
        e.trap.physical_watch_trap = r.addr[63:3] == watch_in.pa_addr[63:3] &&
            |(e.st.byte_en & watch_in.pa_mask);
        {e.trap.data_access_exc, e.trap.data_access_err} = m[3:2];
        {e.trap.quick_translation_miss_trap, e.trap.quick_protection_trap} = m[1:0];
        e.st.secondary = r.space_sel[0];
        e.st.addr = r.addr;
        if (e.trap != '0)
            e.st = '0;
        return e;
    endfunction
    function automatic mps_pkg::mps_req_s mk(logic [7:0] s, logic [63:0] m, logic [63:0] a);
        mps_pkg::mps_req_s r;
        r = '0;
        r.is_alt_store = 1'b1;
        r.space_sel = s;
        r.lane_mask = m;
        r.addr = a;
        r.fp_data = 64'h0123456789abcdef;
        return r;
    endfunction
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Outputs answer at the edge that takes the request, so the next step compares them
    task automatic step(input logic v, input mps_pkg::mps_req_s r, input logic f,
        input logic [3:0] m);
        @(negedge clock_in);
        `CHK("done", e0.done, done_out)
        `CHK("skip", e0.np, not_partial_out)
        `CHK("trap", e0.trap, trap_out)
        `CHK("write", e0.done && e0.trap == '0, store_valid_out)
        `CHK("store", e0.st, store_out)
        for (int k = 0; k < 8; k++)
            if (e0.st.byte_en[k])
                shadow[{e0.st.addr[5:3], 3'(k)}] = e0.st.data[8*k +: 8];
        e0 = v ? predict(r, f, m) : mps_exp_s'('0);
        req_valid_in = v;
        req_in = r;
        fpu_enabled_in = f;
        mmu = m;
    endtask
    initial
    begin
        #16000;
        fails++;
        results();
    end
    initial
    begin
        mps_pkg::mps_req_s q;
        int s;
        s = $urandom(32'hffa5);
        watch_in = '{va_addr: 64'h1000, pa_addr: 64'h2000, va_mask: 8'h01, pa_mask: 8'h80};
        repeat (10) @(posedge clock_in);
        @(negedge clock_in) rst_in = 1'b0;
        foreach (sels[k]) step(1, mk(sels[k], 64'hf5, 64'h40), 1, 0);
        $display("test selectors done");
        step(1, mk(8'hc0, 64'h0, 64'h48), 1, 0);
        step(1, mk(8'hc4, 64'hfffffffffffffffe, 64'h50), 1, 0);
        step(1, mk(8'hc2, 64'hf, 64'h44), 1, 0);
        step(1, mk(8'hc8, 64'hff, 64'h58), 0, 0);
        step(1, mk(8'hc6, 64'hff, 64'h58), 1, 0);
        step(1, mk(8'hc0, 64'h80, 64'h1000), 1, 0);
        step(1, mk(8'hc0, 64'h02, 64'h1000), 1, 0);
        step(1, mk(8'hc1, 64'h01, 64'h2000), 1, 0);
        q = mk(8'hc4, 64'h3, 64'h60);
        q.imm_sel = 1'b1;
        step(1, q, 1, 0);
        q.is_alt_store = 1'b0;
        step(1, q, 1, 0);
        for (int k = 0; k < 4; k++) step(1, mk(8'hca, 64'h9, 64'h68), 1, 4'h1 << k);
        $display("test corners done");
        repeat (400)
        begin
            q = mk($urandom % 8 ? sels[$urandom % 12] : 8'($urandom), {$urandom, $urandom},
                $urandom % 6 ? 64'h1000 : {$urandom, $urandom});
            q.fp_data = {$urandom, $urandom};
            q.imm_sel = $urandom % 16 == 0;
            if ($urandom % 8)
                q.addr[2:0] = 3'h0;
            step($urandom % 4 != 0, q, $urandom % 16 != 0, $urandom % 8 ? 4'h0 : 4'($urandom));
        end
        $display("test random done");
        repeat (2) step(0, '0, 1, 0);
        // Two idle steps let the last write reach the memory model
        for (int k = 0; k < 64; k++) `CHK("memory", shadow[k], mps_mem_model_inst.mem_r[k])
        results();
    end
endmodule
